// ### itsr_core.sv
// Threshold, sync mode and over-voltage response command registers
`timescale 1ns/1ps
`include "itsr_params.svh"
module itsr_core import itsr_pkg::*; #(
	parameter int unsigned HICCUP_CYC = `ITSR_HICCUP_MS * `ITSR_CLK_MHZ * 1000,
	parameter int unsigned UVLO_CYC = 4000,
	parameter int unsigned SW_DIV = 33,
	parameter int unsigned LOSS_CYC = 256
) (
	input wire logic i_clk,           // Block clock, 20 MHz
	input wire logic i_rst,           // Synchronous reset
	input wire itsr_cmd_t i_cmd,      // Command from bus layer
	input wire logic i_bias_ok,       // Bias supply above enable level
	input wire logic i_vin_ge_start,  // Input at or above start level
	input wire logic i_vin_le_stop,   // Input at or below stop level
	input wire logic i_ov_cmp,        // Output over-voltage comparator
	input wire logic i_zero_warn,     // Zero-volt warning
	input wire logic i_enable_pin,    // Enable pin level
	input wire logic i_op_on,         // Operation command says on
	input wire logic i_other_fault,   // Another shutdown fault
	input wire logic i_sync_pin,      // Sync line level
	output logic [15:0] o_rd_data,    // Read data
	output logic o_rd_valid,          // Read data valid pulse
	output logic o_host_alert_n,      // Alert to host, low active
	output logic o_out_en,            // Power conversion allowed
	output logic o_hs_allow,          // High-side switch may turn on
	output logic o_ls_force,          // Low-side switch forced on
	output logic [15:0] o_start_thr,  // Start threshold word
	output logic [15:0] o_stop_thr,   // Stop threshold word
	output logic [2:0] o_ov_sel,      // Over-voltage threshold select
	output logic o_nvm_store,         // Store image pulse
	output itsr_nvm_t o_nvm,          // Image for storage
	output logic o_sync_out,          // Sync line drive value
	output logic o_sync_oe,           // Sync line drive enable
	output logic o_sw_tick            // Switching cycle start pulse
);
	localparam int HW = $clog2(HICCUP_CYC + 1);
	localparam int UW = $clog2(UVLO_CYC + 1);
	localparam int NPIN = 6;

	generate
		if (HICCUP_CYC < 2 || UVLO_CYC < 1) begin : g_bad
			$error("itsr_core: counts too small");
		end
	endgenerate

	// Delay from a two-bit code, least time rounded up to cycles
	function automatic logic [7:0] ov_delay(input logic [1:0] sel);
		unique case (sel)
			2'h0: ov_delay = 8'((`ITSR_DLY0_NS * `ITSR_CLK_MHZ + 999) / 1000);
			2'h1: ov_delay = 8'((`ITSR_DLY1_NS * `ITSR_CLK_MHZ + 999) / 1000);
			2'h2: ov_delay = 8'((`ITSR_DLY2_NS * `ITSR_CLK_MHZ + 999) / 1000);
			2'h3: ov_delay = 8'((`ITSR_DLY3_NS * `ITSR_CLK_MHZ + 999) / 1000);
		endcase
	endfunction

	// Linear word check: fixed exponent, mantissa inside a range
	function automatic logic thr_ok(input logic [15:0] w, input logic [10:0] lo, input logic [10:0] hi);
		thr_ok = (w[15:11] == `ITSR_THR_EXP) && (w[10:0] >= lo) && (w[10:0] <= hi);
	endfunction

	// Pin synchronisers, first stage read only by the second
	logic [NPIN-1:0] pm_q, ps_q;
	logic bias_s, ge_s, le_s, ov_s, zero_s, en_s;

	// Command registers
	logic [15:0] start_q, start_d, stop_q, stop_d, ilv_q, ilv_d, pct_q, pct_d, mode_q, mode_d;
	logic [7:0] ovr_q, ovr_d;
	logic [15:0] rd_d;
	logic rdv_d, store_d;
	itsr_nvm_t nvm_d;

	// Fault flags and strobes
	logic ovf_q, ovf_d, uvf_q, uvf_d, idat_q, idat_d, icmd_q, icmd_d;
	logic set_data, set_cmd, clr, uvlo_set;
	logic [7:0] sbyte;
	logic [15:0] sword;

	// Conversion and response state
	logic conv_q, conv_d;
	logic [UW-1:0] ucnt_q, ucnt_d;
	itsr_ov_t st_q, st_d;
	logic [7:0] ocnt_q, ocnt_d;
	logic [HW-1:0] hcnt_q, hcnt_d;
	logic stop_retry, out_d, hs_d, ls_d, alert_d;
	itsr_sync_t sy_mode;

	assign {bias_s, ge_s, le_s, ov_s, zero_s, en_s} = ps_q;

	// Command decode, write checks and read mux
	always_comb begin
		start_d = start_q;
		stop_d = stop_q;
		ilv_d = ilv_q;
		ovr_d = ovr_q;
		pct_d = pct_q;
		mode_d = mode_q;
		set_data = 1'b0;
		set_cmd = 1'b0;
		clr = 1'b0;
		store_d = 1'b0;
		rd_d = o_rd_data;
		rdv_d = i_cmd.rd;
		// A rejected word never reaches its register
		if (i_cmd.wr) begin
			unique case (i_cmd.code)
				`ITSR_CMD_START: begin
					if (thr_ok(i_cmd.data, `ITSR_START_MIN, `ITSR_START_MAX)
						&& (i_cmd.data[10:0] > stop_q[10:0])) begin
						start_d = i_cmd.data;
					end else begin
						set_data = 1'b1;
					end
				end
				`ITSR_CMD_STOP: begin
					if (thr_ok(i_cmd.data, `ITSR_STOP_MIN, `ITSR_STOP_MAX)
						&& (i_cmd.data[10:0] <= start_q[10:0])) begin
						stop_d = i_cmd.data;
					end else begin
						set_data = 1'b1;
					end
				end
				`ITSR_CMD_ILV: begin
					if (i_cmd.data inside {`ITSR_ILV_ALONE, `ITSR_ILV_MASTER,
						`ITSR_ILV_SLV_IN, `ITSR_ILV_SLV_OUT}) begin
						ilv_d = i_cmd.data;
					end else begin
						set_data = 1'b1;
					end
				end
				`ITSR_CMD_OVR: begin
					if ((i_cmd.data[15:8] == 8'h00) && (i_cmd.data[7:6] <= `ITSR_ACT_DELAY)
						&& (i_cmd.data[5:3] inside {`ITSR_RETRY_LATCH, `ITSR_RETRY_HICCUP})) begin
						ovr_d = i_cmd.data[7:0];
					end else begin
						set_data = 1'b1;
					end
				end
				`ITSR_CMD_PCT: pct_d = i_cmd.data;
				`ITSR_CMD_MODE: mode_d = i_cmd.data;
				`ITSR_CMD_CLEAR: clr = 1'b1;
				`ITSR_CMD_STORE: store_d = 1'b1;
				default: set_cmd = 1'b1;
			endcase
		end
		// Status words built from the latched flags and the output enable
		sbyte = 8'h00;
		sbyte[`ITSR_SB_OFF] = ~o_out_en;
		sbyte[`ITSR_SB_VOUT_OV] = ovf_q;
		sbyte[`ITSR_SB_VIN_UV] = uvf_q;
		sbyte[`ITSR_SB_CML] = idat_q | icmd_q;
		sword = {8'h00, sbyte};
		sword[`ITSR_SW_VOUT] = ovf_q;
		sword[`ITSR_SW_INPUT] = uvf_q;
		if (i_cmd.rd) begin
			unique case (i_cmd.code)
				`ITSR_CMD_START: rd_d = start_q;
				`ITSR_CMD_STOP: rd_d = stop_q;
				`ITSR_CMD_ILV: rd_d = ilv_q;
				`ITSR_CMD_OVR: rd_d = {8'h00, ovr_q};
				`ITSR_CMD_PCT: rd_d = pct_q;
				`ITSR_CMD_MODE: rd_d = mode_q;
				`ITSR_CMD_SBYTE: rd_d = {8'h00, sbyte};
				`ITSR_CMD_SWORD: rd_d = sword;
				`ITSR_CMD_SVOUT: rd_d = 16'(ovf_q) << `ITSR_SV_OV;
				`ITSR_CMD_SINPUT: rd_d = 16'(uvf_q) << `ITSR_SI_UV;
				`ITSR_CMD_SCML: rd_d = (16'(idat_q) << `ITSR_SC_DATA) | (16'(icmd_q) << `ITSR_SC_CMD);
				default: rd_d = 16'h0000;
			endcase
		end
		nvm_d = store_d ? {start_q, stop_q, ilv_q, ovr_q} : o_nvm;
		// Set wins over a clear in the same cycle
		ovf_d = ov_s | (ovf_q & ~clr);
		uvf_d = uvlo_set | (uvf_q & ~clr);
		idat_d = set_data | (idat_q & ~clr);
		icmd_d = set_cmd | (icmd_q & ~clr);
		alert_d = ~(ovf_d | uvf_d | idat_d | icmd_d);
	end

	// Input lockout watch and start/stop of conversion
	always_comb begin
		conv_d = conv_q;
		ucnt_d = ucnt_q;
		uvlo_set = 1'b0;
		if (!bias_s) begin
			conv_d = 1'b0;
			ucnt_d = '0;
		end else if (!conv_q) begin
			if (ge_s) begin
				conv_d = 1'b1;
				ucnt_d = '0;
			end else if (ucnt_q == UW'(UVLO_CYC)) begin
				uvlo_set = 1'b1;
			end else begin
				ucnt_d = ucnt_q + 1'b1;
			end
		end else if (le_s) begin
			conv_d = 1'b0;
			ucnt_d = '0;
		end
	end

	// Over-voltage response sequence
	always_comb begin
		st_d = st_q;
		ocnt_d = ocnt_q;
		hcnt_d = hcnt_q;
		stop_retry = ~en_s | ~i_op_on | ~bias_s | i_other_fault;
		unique case (st_q)
			ST_RUN: begin
				// Action 00 rides through; only the flag records it
				if (ov_s && (ovr_q[7:6] == `ITSR_ACT_DELAY)) begin
					st_d = ST_DLY;
					ocnt_d = ov_delay(ovr_q[1:0]);
				end
			end
			ST_DLY: begin
				if (!ov_s) begin
					st_d = ST_RUN;
				end else if (ocnt_q <= 8'h01) begin
					if (ovr_q[5:3] == `ITSR_RETRY_HICCUP) begin
						st_d = ST_HIC;
						hcnt_d = HW'(HICCUP_CYC - 1);
					end else begin
						st_d = ST_OFF;
					end
				end else begin
					ocnt_d = ocnt_q - 1'b1;
				end
			end
			ST_OFF: begin
				if (clr) begin
					st_d = ST_RUN;
				end
			end
			ST_HIC: begin
				if (stop_retry) begin
					st_d = ST_OFF;
				end else if (hcnt_q == '0) begin
					st_d = ST_RUN;
				end else begin
					hcnt_d = hcnt_q - 1'b1;
				end
			end
			default: st_d = ST_RUN;
		endcase
		out_d = conv_q & en_s & i_op_on & (st_q != ST_OFF) & (st_q != ST_HIC);
		hs_d = out_d & ~zero_s;
		ls_d = out_d & zero_s & mode_q[`ITSR_MODE_LS_BIT];
	end

	// Sync mode decode from the accepted word
	always_comb begin
		unique case (ilv_q)
			`ITSR_ILV_MASTER: sy_mode = SY_MASTER;
			`ITSR_ILV_SLV_IN: sy_mode = SY_IN;
			`ITSR_ILV_SLV_OUT: sy_mode = SY_OUT;
			default: sy_mode = SY_ALONE;
		endcase
	end

	// Sync line, switching tick
	itsr_sync #(
		.SW_DIV(SW_DIV),
		.LOSS_CYC(LOSS_CYC)
	) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_mode(sy_mode),
		.i_sync_pin(i_sync_pin),
		.o_sync_out(o_sync_out),
		.o_sync_oe(o_sync_oe),
		.o_sw_tick(o_sw_tick)
	);

	// All registers of the block
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pm_q <= '0;
			ps_q <= '0;
			start_q <= `ITSR_RST_START;
			stop_q <= `ITSR_RST_STOP;
			ilv_q <= `ITSR_RST_ILV;
			ovr_q <= `ITSR_RST_OVR;
			pct_q <= `ITSR_RST_PCT;
			mode_q <= `ITSR_RST_MODE;
			ovf_q <= 1'b0;
			uvf_q <= 1'b0;
			idat_q <= 1'b0;
			icmd_q <= 1'b0;
			conv_q <= 1'b0;
			ucnt_q <= '0;
			st_q <= ST_RUN;
			ocnt_q <= 8'h00;
			hcnt_q <= '0;
			o_rd_data <= 16'h0000;
			o_rd_valid <= 1'b0;
			o_host_alert_n <= 1'b1;
			o_out_en <= 1'b0;
			o_hs_allow <= 1'b0;
			o_ls_force <= 1'b0;
			o_nvm_store <= 1'b0;
			o_nvm <= '0;
		end else begin
			pm_q <= {i_bias_ok, i_vin_ge_start, i_vin_le_stop, i_ov_cmp, i_zero_warn, i_enable_pin};
			ps_q <= pm_q;
			start_q <= start_d;
			stop_q <= stop_d;
			ilv_q <= ilv_d;
			ovr_q <= ovr_d;
			pct_q <= pct_d;
			mode_q <= mode_d;
			ovf_q <= ovf_d;
			uvf_q <= uvf_d;
			idat_q <= idat_d;
			icmd_q <= icmd_d;
			conv_q <= conv_d;
			ucnt_q <= ucnt_d;
			st_q <= st_d;
			ocnt_q <= ocnt_d;
			hcnt_q <= hcnt_d;
			o_rd_data <= rd_d;
			o_rd_valid <= rdv_d;
			o_host_alert_n <= alert_d;
			o_out_en <= out_d;
			o_hs_allow <= hs_d;
			o_ls_force <= ls_d;
			o_nvm_store <= store_d;
			o_nvm <= nvm_d;
		end
	end

	assign o_start_thr = start_q;
	assign o_stop_thr = stop_q;
	assign o_ov_sel = pct_q[11:9];
endmodule // itsr_core

// ### itsr_params.svh
// Constants for the input threshold, sync and over-voltage response command block
`ifndef ITSR_PARAMS_SVH
`define ITSR_PARAMS_SVH

// Command codes
`define ITSR_CMD_CLEAR 8'h03
`define ITSR_CMD_STORE 8'h15
`define ITSR_CMD_START 8'h35
`define ITSR_CMD_STOP 8'h36
`define ITSR_CMD_ILV 8'h37
`define ITSR_CMD_OVR 8'h41
`define ITSR_CMD_SBYTE 8'h78
`define ITSR_CMD_SWORD 8'h79
`define ITSR_CMD_SVOUT 8'h7A
`define ITSR_CMD_SINPUT 8'h7C
`define ITSR_CMD_SCML 8'h7E
`define ITSR_CMD_PCT 8'hC6
`define ITSR_CMD_MODE 8'hC8

// Reset values
`define ITSR_RST_START 16'hF80C
`define ITSR_RST_STOP 16'hF80C
`define ITSR_RST_ILV 16'h0000
`define ITSR_RST_OVR 8'h40
`define ITSR_RST_PCT 16'h0000
`define ITSR_RST_MODE 16'h0000

// Threshold word fields
`define ITSR_THR_EXP 5'h1F
`define ITSR_START_MIN 11'h006
`define ITSR_START_MAX 11'h015
`define ITSR_STOP_MIN 11'h005
`define ITSR_STOP_MAX 11'h014

// Accepted sync words
`define ITSR_ILV_ALONE 16'h0000
`define ITSR_ILV_MASTER 16'h0100
`define ITSR_ILV_SLV_IN 16'h0120
`define ITSR_ILV_SLV_OUT 16'h0121

// Response byte fields and codes, and the low-side bit of the mode word
`define ITSR_ACT_CONT 2'h0
`define ITSR_ACT_DELAY 2'h1
`define ITSR_RETRY_LATCH 3'h0
`define ITSR_RETRY_HICCUP 3'h7
`define ITSR_MODE_LS_BIT 2

// Status bit positions
`define ITSR_SB_OFF 6
`define ITSR_SB_VOUT_OV 5
`define ITSR_SB_VIN_UV 3
`define ITSR_SB_CML 1
`define ITSR_SW_VOUT 15
`define ITSR_SW_INPUT 13
`define ITSR_SV_OV 7
`define ITSR_SI_UV 4
`define ITSR_SC_DATA 7
`define ITSR_SC_CMD 6

// Timing
`define ITSR_CLK_MHZ 20
`define ITSR_DLY0_NS 6250
`define ITSR_DLY1_NS 7500
`define ITSR_DLY2_NS 8750
`define ITSR_DLY3_NS 10000
`define ITSR_HICCUP_MS 1000

`endif

// ### itsr_pkg.sv
// Types shared by the threshold, sync and over-voltage response block
package itsr_pkg;

	// One command from the bus interface layer
	typedef struct packed {
		logic wr;          // Write strobe
		logic rd;          // Read strobe
		logic [7:0] code;  // Command code
		logic [15:0] data; // Write data
	} itsr_cmd_t;

	// Image handed to nonvolatile storage
	typedef struct packed {
		logic [15:0] start;
		logic [15:0] stop;
		logic [15:0] ilv;
		logic [7:0] ovr;
	} itsr_nvm_t;

	// Sync line modes
	typedef enum logic [3:0] {
		SY_ALONE = 4'b0001,
		SY_MASTER = 4'b0010,
		SY_IN = 4'b0100,
		SY_OUT = 4'b1000
	} itsr_sync_t;

	// Over-voltage response states
	typedef enum logic [3:0] {
		ST_RUN = 4'b0001,
		ST_DLY = 4'b0010,
		ST_OFF = 4'b0100,
		ST_HIC = 4'b1000
	} itsr_ov_t;

endpackage

// ### itsr_sync.sv
// Sync line handling: master drive, slave lock, internal fallback
`timescale 1ns/1ps
module itsr_sync import itsr_pkg::*; #(
	parameter int unsigned SW_DIV = 33,
	parameter int unsigned LOSS_CYC = 256
) (
	input wire logic i_clk,          // Block clock
	input wire logic i_rst,          // Synchronous reset
	input wire itsr_sync_t i_mode,   // Decoded sync mode
	input wire logic i_sync_pin,     // Raw sync line level
	output logic o_sync_out,         // Sync line drive value
	output logic o_sync_oe,          // Sync line drive enable
	output logic o_sw_tick           // Switching cycle start pulse
);
	localparam int DW = $clog2(SW_DIV);
	localparam int LW = $clog2(LOSS_CYC + 1);

	generate
		if (SW_DIV < 4 || LOSS_CYC < SW_DIV) begin : g_bad
			$error("itsr_sync: bad divider or loss window");
		end
	endgenerate

	logic m_q, s_q, p_q;          // Two-stage sync, then edge history
	logic [DW-1:0] div_q, div_d;  // Internal switching divider
	logic [LW-1:0] los_q, los_d;  // Cycles since last sync edge
	logic out_d, oe_d, tick_d;
	logic slave, ext_edge, present, int_tick;

	// Next-value logic
	always_comb begin
		slave = (i_mode == SY_IN) || (i_mode == SY_OUT);
		int_tick = (div_q == DW'(SW_DIV - 1));
		// Falling edge of a half-duty master clock gives the opposite phase
		ext_edge = (i_mode == SY_OUT) ? (p_q & ~s_q) : (s_q & ~p_q);
		present = (los_q < LW'(LOSS_CYC));
		div_d = int_tick ? '0 : div_q + 1'b1;
		los_d = los_q;
		if (!slave) begin
			los_d = LW'(LOSS_CYC);
		end else if (ext_edge) begin
			los_d = '0;
		end else if (present) begin
			los_d = los_q + 1'b1;
		end
		if (slave && present) begin
			// Realign the divider so fallback keeps the last phase
			tick_d = ext_edge;
			if (ext_edge) begin
				div_d = '0;
			end
		end else begin
			tick_d = int_tick;
		end
		oe_d = (i_mode == SY_MASTER);
		out_d = oe_d && (div_q < DW'(SW_DIV / 2));
	end

	// Registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			m_q <= 1'b0;
			s_q <= 1'b0;
			p_q <= 1'b0;
			div_q <= '0;
			los_q <= LW'(LOSS_CYC);
			o_sync_out <= 1'b0;
			o_sync_oe <= 1'b0;
			o_sw_tick <= 1'b0;
		end else begin
			m_q <= i_sync_pin;
			s_q <= m_q;
			p_q <= s_q;
			div_q <= div_d;
			los_q <= los_d;
			o_sync_out <= out_d;
			o_sync_oe <= oe_d;
			o_sw_tick <= tick_d;
		end
	end
endmodule // itsr_sync

// ### itsr_core_checker.sv
// Concurrent checks on the command register block, bound to its top
`timescale 1ns/1ps
module itsr_core_checker import itsr_pkg::*; (
	input wire logic i_clk,              // Block clock
	input wire logic i_rst,              // Synchronous reset
	input wire itsr_cmd_t i_cmd,         // Command from bus layer
	input wire logic i_ov_cmp,           // Over-voltage comparator
	input wire logic i_zero_warn,        // Zero-volt warning
	input wire logic [15:0] o_rd_data,   // Read data
	input wire logic o_rd_valid,         // Read data valid
	input wire logic o_host_alert_n,     // Alert to host, low active
	input wire logic o_out_en,           // Conversion allowed
	input wire logic o_hs_allow,         // High side allowed
	input wire logic [15:0] o_start_thr, // Start threshold word
	input wire logic [15:0] o_stop_thr,  // Stop threshold word
	input wire logic o_nvm_store,        // Store pulse
	input wire itsr_nvm_t o_nvm,         // Stored image
	input wire logic o_sync_oe           // Sync drive enable
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Decoded writes; the mantissa bounds are checked on the low eleven bits
	wire logic wr_start = i_cmd.wr && i_cmd.code == 8'h35;
	wire logic wr_stop = i_cmd.wr && i_cmd.code == 8'h36;
	wire logic wr_clr = i_cmd.wr && i_cmd.code == 8'h03;
	wire logic start_bad = i_cmd.data[15:11] != 5'h1F || i_cmd.data[10:0] < 11'h006 || i_cmd.data[10:0] > 11'h015;
	wire logic stop_bad = i_cmd.data[15:11] != 5'h1F || i_cmd.data[10:0] < 11'h005 || i_cmd.data[10:0] > 11'h014;

	a_start_range: assert property (wr_start && start_bad |=> $stable(o_start_thr) && !o_host_alert_n)
		else $error("start code outside range was taken");
	a_stop_range: assert property (wr_stop && stop_bad |=> $stable(o_stop_thr) && !o_host_alert_n)
		else $error("stop code outside range was taken");
	a_start_order: assert property (wr_start && i_cmd.data[10:0] <= o_stop_thr[10:0] |=> $stable(o_start_thr))
		else $error("start at or below stop was taken");
	a_stop_order: assert property (wr_stop && i_cmd.data[10:0] > o_start_thr[10:0] |=> $stable(o_stop_thr))
		else $error("stop above start was taken");
	a_start_read: assert property (i_cmd.rd && i_cmd.code == 8'h35 |=> o_rd_valid && o_rd_data == $past(o_start_thr))
		else $error("start word read back wrong");
	a_ov_alert: assert property (i_ov_cmp [*4] |=> !o_host_alert_n)
		else $error("over-voltage did not pull alert");
	a_alert_sticky: assert property ($rose(o_host_alert_n) && !$past(i_rst) |-> $past(wr_clr))
		else $error("alert released without clear");
	a_zero_hs: assert property (i_zero_warn [*4] |=> !o_hs_allow)
		else $error("high side allowed during zero-volt warning");
	a_store_image: assert property (o_nvm_store |-> o_nvm.start == o_start_thr && o_nvm.stop == o_stop_thr)
		else $error("stored image differs from registers");
	// Main scenarios reached
	c_store: cover property (o_nvm_store);
	c_shutdown: cover property ($fell(o_out_en));
	c_master: cover property (o_sync_oe);
endmodule // itsr_core_checker

bind itsr_core itsr_core_checker u_itsr_core_checker (.i_clk(i_clk), .i_rst(i_rst), .i_cmd(i_cmd),
	.i_ov_cmp(i_ov_cmp), .i_zero_warn(i_zero_warn), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
	.o_host_alert_n(o_host_alert_n), .o_out_en(o_out_en), .o_hs_allow(o_hs_allow), .o_start_thr(o_start_thr),
	.o_stop_thr(o_stop_thr), .o_nvm_store(o_nvm_store), .o_nvm(o_nvm), .o_sync_oe(o_sync_oe));

// ### itsr_peer.sv
// Peer converter that puts its switching clock on the shared sync line
`timescale 1ns/1ps
module itsr_peer #(
	parameter int HALF_NS = 200
) (
	input wire logic i_run, // Clock the line while high
	output logic o_line     // Level this peer leaves on the line
);
	// Clock only inside a run; on release leave the inverse, never a stale level
	// One process owns the line, so the idle level and the clocking never race
	initial begin
		o_line = 1'h0;
		forever begin
			@(posedge i_run);
			while (i_run) begin
				#(HALF_NS) o_line = ~o_line;
			end
			o_line = ~o_line;
		end
	end
endmodule // itsr_peer

// ### tb_itsr_core.sv
// Self-checking bench for the command register block
`timescale 1ns/1ps
module tb_itsr_core;
	import itsr_pkg::*;
	logic clk, rst = 1'h1, bias = 1'h0, ge = 1'h0, le = 1'h0, ov = 1'h0, zw = 1'h0, en = 1'h0, opon = 1'h0;
	logic oth = 1'h0, peer_run = 1'h0, pin_prev = 1'h0;
	itsr_cmd_t cmd = '0;
	logic [15:0] rdd, st, sp;
	logic [2:0] sel;
	logic rdv, alert_n, out_en, hs, ls, nst, so, soe, tick;
	itsr_nvm_t nvm;
	wire logic peer_line;
	wire logic pin_w = soe ? so : peer_line; // Design drive wins while enabled
	int err_count = 0, comparisons = 0, tick_n, tick_hi;
	// Code, write data, expected read back; a mismatch of the last two means refused
	logic [39:0] tbl [23] = '{40'h36_F805_F805, 40'h35_F806_F806, 40'h35_F815_F815, 40'h35_F816_F815,
		40'h35_0810_F815, 40'h36_F815_F805, 40'h36_F814_F814, 40'h35_F814_F815, 40'h36_F80A_F80A,
		40'h35_F80B_F80B, 40'h36_F80C_F80A, 40'h37_0100_0100, 40'h37_0120_0120, 40'h37_0121_0121,
		40'h37_0101_0121, 40'h37_0000_0000, 40'h41_003B_003B, 40'h41_0080_003B, 40'h41_00C0_003B,
		40'h41_0048_003B, 40'h41_0070_003B, 40'h41_0140_003B, 40'h41_0040_0040};

	itsr_core #(.HICCUP_CYC(50), .UVLO_CYC(20)) u_itsr_core (.i_clk(clk), .i_rst(rst), .i_cmd(cmd),
		.i_bias_ok(bias), .i_vin_ge_start(ge), .i_vin_le_stop(le), .i_ov_cmp(ov), .i_zero_warn(zw),
		.i_enable_pin(en), .i_op_on(opon), .i_other_fault(oth), .i_sync_pin(pin_w), .o_rd_data(rdd),
		.o_rd_valid(rdv), .o_host_alert_n(alert_n), .o_out_en(out_en), .o_hs_allow(hs), .o_ls_force(ls),
		.o_start_thr(st), .o_stop_thr(sp), .o_ov_sel(sel), .o_nvm_store(nst), .o_nvm(nvm), .o_sync_out(so),
		.o_sync_oe(soe), .o_sw_tick(tick));
	itsr_peer u_itsr_peer (.i_run(peer_run), .o_line(peer_line));

	// 20 MHz block clock
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// Tick tally; the line level a cycle earlier tells which sync edge was followed
	always @(negedge clk) begin
		if (tick === 1'h1) begin
			tick_n++;
			tick_hi += pin_prev;
		end
		pin_prev = pin_w;
	end

	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// One-cycle command pulses, launched on the falling edge
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk);
		cmd = {1'h1, 1'h0, c, d};
		@(negedge clk);
		cmd = '0;
	endtask
	task automatic rd(input logic [7:0] c, input logic [15:0] exp, input string nm);
		int k;
		@(negedge clk);
		cmd = {1'h0, 1'h1, c, 16'h0000};
		@(negedge clk);
		cmd = '0;
		k = 0;
		// Bounded wait for the answer pulse
		while (rdv !== 1'h1 && k < 3) begin
			@(negedge clk);
			k++;
		end
		chk("rd_valid", rdv, 1'h1);
		chk(nm, rdd, exp);
	endtask

	task automatic t_regs();
		rd(8'h35, 16'hF80C, "start_rst");
		rd(8'h36, 16'hF80C, "stop_rst");
		rd(8'h37, 16'h0000, "ilv_rst");
		rd(8'h41, 16'h0040, "ovr_rst");
		foreach (tbl[i]) begin
			wr(8'h03, 16'h0000);
			wr(tbl[i][39:32], tbl[i][31:16]);
			rd(tbl[i][39:32], tbl[i][15:0], "reg");
			rd(8'h7E, (tbl[i][15:0] != tbl[i][31:16]) ? 16'h0080 : 16'h0000, "bad_data");
			chk("alert", alert_n, tbl[i][15:0] == tbl[i][31:16]);
		end
		// Unknown command code raises the command flag until cleared
		wr(8'h03, 16'h0000);
		wr(8'hD0, 16'h0000);
		rd(8'h7E, 16'h0040, "bad_cmd");
		wr(8'h03, 16'h0000);
		rd(8'h7E, 16'h0000, "cml_clear");
		chk("start_out", st, 16'hF80B);
		chk("stop_out", sp, 16'hF80A);
		wr(8'h15, 16'h0000);
		chk("store_pulse", nst, 1'h1);
		chk("image", nvm, {8'h00, 16'hF80B, 16'hF80A, 16'h0000, 8'h40});
	endtask

	task automatic t_sync();
		int hi;
		wr(8'h37, 16'h0100);
		cyc(40);
		hi = 0;
		repeat (33) begin
			@(negedge clk);
			hi += so;
		end
		chk("master_high", hi, 16);
		chk("master_oe", soe, 1'h1);
		wr(8'h37, 16'h0000);
		peer_run = 1'h1;
		cyc(20);
		chk("alone_oe", soe, 1'h0);
		// Standalone keeps its own rate although the peer clocks the line
		tick_n = 0;
		cyc(330);
		chk("alone_ticks", tick_n inside {[9:11]}, 1'h1);
		for (int m = 0; m < 2; m++) begin
			wr(8'h37, 16'h0120 | m[15:0]);
			cyc(20);
			tick_n = 0;
			tick_hi = 0;
			cyc(200);
			chk("slave_ticks", tick_n inside {[24:26]}, 1'h1);
			chk("slave_phase", tick_hi, (m == 0) ? tick_n : 0);
		end
		peer_run = 1'h0;
		cyc(300);
		tick_n = 0;
		cyc(330);
		chk("fallback", tick_n inside {[9:11]}, 1'h1);
		wr(8'h37, 16'h0000);
	endtask

	task automatic t_ov();
		bias = 1'h1;
		ge = 1'h1;
		en = 1'h1;
		opon = 1'h1;
		cyc(10);
		wr(8'h03, 16'h0000);
		for (int k = 0; k < 4; k++) begin
			wr(8'h41, 16'h0040 | k[15:0]);
			ov = 1'h1;
			cyc(120 + 25 * k);
			chk("delay_on", out_en, 1'h1);
			cyc(15);
			chk("delay_off", out_en, 1'h0);
			rd(8'h79, 16'h8060, "status_word");
			ov = 1'h0;
			cyc(100);
			chk("latched", out_en, 1'h0);
			rd(8'h78, 16'h0060, "status_byte");
			rd(8'h7A, 16'h0080, "status_vout");
			wr(8'h03, 16'h0000);
			cyc(5);
			chk("cleared", out_en, 1'h1);
		end
		wr(8'h41, 16'h0078);
		ov = 1'h1;
		cyc(140);
		chk("hiccup_off", out_en, 1'h0);
		ov = 1'h0;
		cyc(60);
		chk("hiccup_back", out_en, 1'h1);
		ov = 1'h1;
		cyc(140);
		en = 1'h0;
		cyc(5);
		en = 1'h1;
		ov = 1'h0;
		cyc(100);
		chk("retry_stop", out_en, 1'h0);
		wr(8'h41, 16'h0000);
		wr(8'h03, 16'h0000);
		ov = 1'h1;
		cyc(300);
		chk("ride_through", out_en, 1'h1);
		chk("ride_alert", alert_n, 1'h0);
		chk("hs_run", hs, 1'h1);
		ov = 1'h0;
	endtask

	task automatic t_misc();
		zw = 1'h1;
		cyc(5);
		chk("zero_hs", hs, 1'h0);
		chk("zero_ls", ls, 1'h0);
		wr(8'hC8, 16'h0004);
		cyc(2);
		chk("zero_ls_on", ls, 1'h1);
		zw = 1'h0;
		wr(8'hC6, 16'h0A00);
		chk("ov_select", sel, 3'h5);
		// A falling input drops below start as it reaches stop; both high at once is not physical
		le = 1'h1;
		ge = 1'h0;
		cyc(5);
		chk("stop_conv", out_en, 1'h0);
		le = 1'h0;
		cyc(40);
		rd(8'h7C, 16'h0010, "lockout");
	endtask

	// Verdict and end of run, shared with the watchdog
	task automatic final_report();
		$display("comparisons %0d err_count %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Whole run is near 3700 cycles; this allows over sixteen times that
	initial begin
		#3000000;
		err_count++;
		final_report();
	end

	initial begin
		repeat (16) @(negedge clk);
		rst = 1'h0;
		t_regs();
		t_sync();
		t_ov();
		t_misc();
		final_report();
	end
endmodule // tb_itsr_core
